// ==== hdl/llsf_pkg.sv ====
// Shared constants for the lane link status flag bank
package llsf_pkg;
  localparam int ADDR_W = 12; // Configuration port address width
  localparam int DATA_W = 8; // Configuration port data width
  localparam int THRESH_W = 8; // Error threshold field width
  localparam logic [11:0] LANE2_STATUS_ADDR = 12'h4B2; // Lane 2 status register
  localparam logic [11:0] LANE3_STATUS_ADDR = 12'h4B3; // Lane 3 status register
  localparam logic [7:0] STATUS_RESET = 8'h00; // Reset value of both registers
  localparam logic [7:0] READ_UNMAPPED = 8'h00; // Read data of unmapped offsets
  localparam int BIT_DISPARITY = 7; // Bad disparity count at threshold
  localparam int BIT_BADCODE = 6; // Not-in-table count at threshold
  localparam int BIT_UNEXP_CTRL = 5; // Unexpected control count at threshold
  localparam int BIT_DESKEW = 4; // Interlane deskew achieved
  localparam int BIT_INIT_ALIGN = 3; // Initial lane alignment achieved
  localparam int BIT_CHECKSUM = 2; // Checksum correct
  localparam int BIT_FRAME_LOCK = 1; // Frame synchronization achieved
  localparam int BIT_CG_LOCK = 0; // Code group synchronization achieved
endpackage

// ==== hdl/llsf_lane_flags.sv ====
// One lane's status flag register, rebuilt from live lane state every cycle
`timescale 1ns/1ps
`default_nettype none
module llsf_lane_flags
  import llsf_pkg::*;
#(
  parameter int CNT_W = 8 // Error counter width, at least the threshold width
) (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic [CNT_W-1:0] disparity_count, // Bad disparity error count
  input wire logic [CNT_W-1:0] badcode_count, // Not-in-table error count
  input wire logic [CNT_W-1:0] unexpected_ctrl_count, // Unexpected control count
  input wire logic [THRESH_W-1:0] error_threshold, // Programmed error threshold
  input wire logic skip_alignment_sequence, // Alignment sequence disabled
  input wire logic deskew_ok, // Interlane deskew achieved
  input wire logic initial_align_ok, // Initial lane alignment achieved
  input wire logic checksum_ok, // Computed checksum matches
  input wire logic frame_lock, // Frame synchronization achieved
  input wire logic codegroup_lock, // Code group synchronization achieved
  output logic [DATA_W-1:0] status // Packed status flags
);

  // Count at or above threshold; threshold zero-extended to counter width
  function automatic logic at_threshold(input logic [CNT_W-1:0] cnt,
                                        input logic [THRESH_W-1:0] thr);
    at_threshold = (cnt >= CNT_W'(thr));
  endfunction

  // Alignment-derived results have no meaning with the sequence skipped,
  // so they read as 0 rather than exposing stale sequence state
  logic align_valid; // Alignment sequence in use
  assign align_valid = !skip_alignment_sequence;

  logic [DATA_W-1:0] next_status; // Flags to load at next edge

  // Pack the flags at their fixed positions
  always_comb begin
    next_status = STATUS_RESET;
    next_status[BIT_DISPARITY] = at_threshold(disparity_count, error_threshold);
    next_status[BIT_BADCODE] = at_threshold(badcode_count, error_threshold);
    next_status[BIT_UNEXP_CTRL] =
      at_threshold(unexpected_ctrl_count, error_threshold);
    next_status[BIT_DESKEW] = deskew_ok && align_valid;
    next_status[BIT_INIT_ALIGN] = initial_align_ok && align_valid;
    next_status[BIT_CHECKSUM] = checksum_ok && align_valid;
    next_status[BIT_FRAME_LOCK] = frame_lock && align_valid;
    // Code group lock does not depend on the alignment sequence
    next_status[BIT_CG_LOCK] = codegroup_lock;
  end

  // Registered so the read path sees a glitch-free snapshot
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/llsf_top.sv ====
// Lane 2 and lane 3 link status flag registers on the configuration port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Lane 2 bit 7: disparity count >= threshold
// - Lane 2 bit 6: not-in-table count >= threshold
// - Lane 2 bit 5: unexpected control count >= threshold
// - Lane 2 bit 4: deskew achieved, alignment dependent
// - Lane 2 bit 3: initial alignment achieved, alignment dependent
// - Lane 2 bit 2: checksum correct, alignment dependent
// - Lane 2 bit 1: frame lock, alignment dependent
// - Lane 2 bit 0: code group lock, always valid
// - Lane 3 register at 0x4B3; bit 7 disparity
// - Lane 3 bit 6: not-in-table count >= threshold
// - Lane 3 bit 5: unexpected control count >= threshold
// - Lane 3 bit 4: deskew achieved, alignment dependent
// - Lane 3 bit 3: initial alignment, alignment dependent
// - Lane 3 bit 2: checksum correct, alignment dependent
// - Lane 3 bit 1: frame lock, alignment dependent
module llsf_top
  import llsf_pkg::*;
#(
  parameter int CNT_W = 8 // Error counter width
) (
  input wire logic core_clk, // Core clock, 250 MHz
  input wire logic reset, // Asynchronous reset, active high
  input wire logic cfg_rd_en, // Register read strobe
  input wire logic cfg_wr_en, // Register write strobe
  input wire logic [ADDR_W-1:0] cfg_addr, // Register address
  input wire logic [DATA_W-1:0] cfg_wr_data, // Write data, never stored
  output logic [DATA_W-1:0] cfg_rd_data, // Read data
  output logic cfg_rd_valid, // Read data valid pulse
  output logic cfg_wr_refused, // Write hit a read-only flag register
  input wire logic [THRESH_W-1:0] error_threshold, // Programmed error threshold
  input wire logic skip_alignment_sequence, // Alignment sequence disabled
  input wire logic [CNT_W-1:0] lane2_disparity_count, // Lane 2 bad disparity count
  input wire logic [CNT_W-1:0] lane2_badcode_count, // Lane 2 not-in-table count
  input wire logic [CNT_W-1:0] lane2_unexp_ctrl_count, // Lane 2 unexpected control
  input wire logic lane2_deskew_ok, // Lane 2 deskew achieved
  input wire logic lane2_init_align_ok, // Lane 2 initial alignment achieved
  input wire logic lane2_checksum_ok, // Lane 2 checksum correct
  input wire logic lane2_frame_lock, // Lane 2 frame lock
  input wire logic lane2_codegroup_lock, // Lane 2 code group lock
  input wire logic [CNT_W-1:0] lane3_disparity_count, // Lane 3 bad disparity count
  input wire logic [CNT_W-1:0] lane3_badcode_count, // Lane 3 not-in-table count
  input wire logic [CNT_W-1:0] lane3_unexp_ctrl_count, // Lane 3 unexpected control
  input wire logic lane3_deskew_ok, // Lane 3 deskew achieved
  input wire logic lane3_init_align_ok, // Lane 3 initial alignment achieved
  input wire logic lane3_checksum_ok, // Lane 3 checksum correct
  input wire logic lane3_frame_lock, // Lane 3 frame lock
  input wire logic lane3_codegroup_lock, // Lane 3 code group lock
  output logic [DATA_W-1:0] lane2_link_status, // Lane 2 flags, from flip-flops
  output logic [DATA_W-1:0] lane3_link_status // Lane 3 flags, from flip-flops
);

  // Lane 2 flag register; bits 7..0 per the lane flag layout
  llsf_lane_flags #(.CNT_W(CNT_W)) u_lane2 (
    .core_clk(core_clk),
    .reset(reset),
    .disparity_count(lane2_disparity_count),
    .badcode_count(lane2_badcode_count),
    .unexpected_ctrl_count(lane2_unexp_ctrl_count),
    .error_threshold(error_threshold),
    .skip_alignment_sequence(skip_alignment_sequence),
    .deskew_ok(lane2_deskew_ok),
    .initial_align_ok(lane2_init_align_ok),
    .checksum_ok(lane2_checksum_ok),
    .frame_lock(lane2_frame_lock),
    .codegroup_lock(lane2_codegroup_lock),
    .status(lane2_link_status)
  );

  // Lane 3 flag register, same layout as lane 2
  llsf_lane_flags #(.CNT_W(CNT_W)) u_lane3 (
    .core_clk(core_clk),
    .reset(reset),
    .disparity_count(lane3_disparity_count),
    .badcode_count(lane3_badcode_count),
    .unexpected_ctrl_count(lane3_unexp_ctrl_count),
    .error_threshold(error_threshold),
    .skip_alignment_sequence(skip_alignment_sequence),
    .deskew_ok(lane3_deskew_ok),
    .initial_align_ok(lane3_init_align_ok),
    .checksum_ok(lane3_checksum_ok),
    .frame_lock(lane3_frame_lock),
    .codegroup_lock(lane3_codegroup_lock),
    .status(lane3_link_status)
  );

  // Address decode for the two flag registers
  function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
    decode = {a == LANE3_STATUS_ADDR, a == LANE2_STATUS_ADDR};
  endfunction

  logic [DATA_W-1:0] next_rd_data; // Selected read data
  logic [1:0] rd_hit; // Read address hits {lane3, lane2}
  logic [1:0] wr_hit; // Write address hits {lane3, lane2}

  assign rd_hit = decode(cfg_addr);
  assign wr_hit = decode(cfg_addr);

  // Read mux; unmapped offsets read as zero
  always_comb begin
    case (rd_hit)
      2'h1: next_rd_data = lane2_link_status;
      2'h2: next_rd_data = lane3_link_status;
      default: next_rd_data = READ_UNMAPPED;
    endcase
  end

  // Read answer one cycle after the strobe; data holds until next read
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_rd_data <= READ_UNMAPPED;
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd_en;
      if (cfg_rd_en) begin
        cfg_rd_data <= next_rd_data;
      end
    end
  end

  // Writes are never stored: flags only follow lane state. A write that
  // targets a flag register is flagged so software can spot the mistake.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_wr_refused <= 1'b0;
    end else begin
      cfg_wr_refused <= cfg_wr_en && (wr_hit != 2'h0);
    end
  end

  // Checking helper: high from the second edge after reset release on,
  // so $past never reaches back into reset
  logic chk_up; // Checks armed
  logic chk_up_d; // Delay stage
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chk_up_d <= 1'b0;
      chk_up <= 1'b0;
    end else begin
      chk_up_d <= 1'b1;
      chk_up <= chk_up_d;
    end
  end

  // Threshold flag follows last cycle's count against threshold
  property p_thresh(logic [CNT_W-1:0] cnt, logic flag);
    @(posedge core_clk) disable iff (reset)
      chk_up |-> (flag == ($past(cnt) >= CNT_W'($past(error_threshold))));
  endproperty

  // Alignment flag follows its source, forced low with the sequence skipped
  property p_align(logic src, logic flag);
    @(posedge core_clk) disable iff (reset)
      chk_up |-> (flag == ($past(src) && !$past(skip_alignment_sequence)));
  endproperty

  // Code group lock follows its source regardless of the skip option
  property p_cg(logic src, logic flag);
    @(posedge core_clk) disable iff (reset)
      chk_up |-> (flag == $past(src));
  endproperty

  AST_L2_DISP: assert property (p_thresh(lane2_disparity_count, lane2_link_status[7]))
    else $error("lane 2 disparity flag wrong");
  AST_L2_BADCODE: assert property (p_thresh(lane2_badcode_count, lane2_link_status[6]))
    else $error("lane 2 not-in-table flag wrong");
  AST_L2_UNEXP: assert property (p_thresh(lane2_unexp_ctrl_count, lane2_link_status[5]))
    else $error("lane 2 unexpected control flag wrong");
  AST_L2_DESKEW: assert property (p_align(lane2_deskew_ok, lane2_link_status[4]))
    else $error("lane 2 deskew flag wrong");
  AST_L2_INIT: assert property (p_align(lane2_init_align_ok, lane2_link_status[3]))
    else $error("lane 2 initial alignment flag wrong");
  AST_L2_CKS: assert property (p_align(lane2_checksum_ok, lane2_link_status[2]))
    else $error("lane 2 checksum flag wrong");
  AST_L2_FRAME: assert property (p_align(lane2_frame_lock, lane2_link_status[1]))
    else $error("lane 2 frame lock flag wrong");
  AST_L2_CG: assert property (p_cg(lane2_codegroup_lock, lane2_link_status[0]))
    else $error("lane 2 code group flag wrong");
  AST_L3_DISP: assert property (p_thresh(lane3_disparity_count, lane3_link_status[7]))
    else $error("lane 3 disparity flag wrong");
  AST_L3_BADCODE: assert property (p_thresh(lane3_badcode_count, lane3_link_status[6]))
    else $error("lane 3 not-in-table flag wrong");
  AST_L3_UNEXP: assert property (p_thresh(lane3_unexp_ctrl_count, lane3_link_status[5]))
    else $error("lane 3 unexpected control flag wrong");
  AST_L3_DESKEW: assert property (p_align(lane3_deskew_ok, lane3_link_status[4]))
    else $error("lane 3 deskew flag wrong");
  AST_L3_INIT: assert property (p_align(lane3_init_align_ok, lane3_link_status[3]))
    else $error("lane 3 initial alignment flag wrong");
  AST_L3_CKS: assert property (p_align(lane3_checksum_ok, lane3_link_status[2]))
    else $error("lane 3 checksum flag wrong");
  AST_L3_FRAME: assert property (p_align(lane3_frame_lock, lane3_link_status[1]))
    else $error("lane 3 frame lock flag wrong");
  AST_L3_CG: assert property (p_cg(lane3_codegroup_lock, lane3_link_status[0]))
    else $error("lane 3 code group flag wrong");

  // Read of lane 3 offset returns that register's value one cycle later
  sequence s_rd_lane3;
    cfg_rd_en && (cfg_addr == LANE3_STATUS_ADDR);
  endsequence

  sequence s_answer_lane3;
    ##1 (cfg_rd_valid && (cfg_rd_data == $past(lane3_link_status)));
  endsequence

  AST_RD_LANE3: assert property (@(posedge core_clk) disable iff (reset)
    s_rd_lane3 |-> s_answer_lane3)
    else $error("lane 3 read answer wrong");

  // A write to a flag register is refused next cycle and leaves no trace
  sequence s_wr_flag_reg;
    cfg_wr_en && (cfg_addr == LANE2_STATUS_ADDR || cfg_addr == LANE3_STATUS_ADDR);
  endsequence

  AST_WR_REFUSED: assert property (@(posedge core_clk) disable iff (reset)
    s_wr_flag_reg |=> cfg_wr_refused)
    else $error("write to flag register not refused");

  // Flags still hold the reset value as sampled at the first edge after release
  AST_RESET_ZERO: assert property (@(posedge core_clk)
    reset |=> (lane2_link_status == STATUS_RESET &&
               lane3_link_status == STATUS_RESET))
    else $error("flags not cleared by reset");

endmodule
`default_nettype wire

// ==== verification/llsf_link_tx_model.sv ====
// Serial link transmitter model that drives lane error counts and sync levels
`timescale 1ns/1ps
`default_nettype none
module llsf_link_tx_model (
  input wire logic core_clk, // Core clock
  input wire logic [57:0] lane_plan, // Next lane 3 and lane 2 state
  output logic [28:0] lane2_state, // Counts then deskew, align, checksum, frame, code group
  output logic [28:0] lane3_state // Same layout for lane 3
);
  // Lane state moves on the falling edge, so the receiver always samples settled levels;
  // levels are unknown until the first falling edge, which reset covers
  always @(negedge core_clk) begin
    lane2_state <= lane_plan[28:0];
    lane3_state <= lane_plan[57:29];
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the lane 2 and lane 3 status flag registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import llsf_pkg::*;
  logic core_clk, reset, cfg_rd_en, cfg_wr_en, skip; // Clock, reset and strobes
  logic [ADDR_W-1:0] cfg_addr; // Register address
  logic [DATA_W-1:0] cfg_wr_data, cfg_rd_data, exp2, exp3; // Data and expected flags
  logic cfg_rd_valid, cfg_wr_refused, wr_pend; // Answers and expected refusal
  logic [7:0] thr, thr_nxt; // Threshold now and the one the counts aim at
  logic [57:0] lane_plan; // Lane state handed to the transmitter model
  logic [28:0] l2, l3; // Lane state seen by the receiver
  logic [15:0] rnd; // Random source
  logic [7:0] rdq[$]; // Expected read data, oldest first
  logic [7:0] rd_last; // Read data the design must still be showing
  logic [DATA_W-1:0] st2, st3; // Flag registers as the design shows them
  int err_total, checks; // Mismatch and comparison counters

  llsf_link_tx_model i_tx (.core_clk(core_clk), .lane_plan(lane_plan), .lane2_state(l2),
    .lane3_state(l3));
  llsf_top #(.CNT_W(8)) i_dut (.core_clk(core_clk), .reset(reset), .cfg_rd_en(cfg_rd_en),
    .cfg_wr_en(cfg_wr_en), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid), .cfg_wr_refused(cfg_wr_refused),
    .error_threshold(thr), .skip_alignment_sequence(skip),
    .lane2_disparity_count(l2[28:21]), .lane2_badcode_count(l2[20:13]),
    .lane2_unexp_ctrl_count(l2[12:5]), .lane2_deskew_ok(l2[4]), .lane2_init_align_ok(l2[3]),
    .lane2_checksum_ok(l2[2]), .lane2_frame_lock(l2[1]), .lane2_codegroup_lock(l2[0]),
    .lane3_disparity_count(l3[28:21]), .lane3_badcode_count(l3[20:13]),
    .lane3_unexp_ctrl_count(l3[12:5]), .lane3_deskew_ok(l3[4]), .lane3_init_align_ok(l3[3]),
    .lane3_checksum_ok(l3[2]), .lane3_frame_lock(l3[1]), .lane3_codegroup_lock(l3[0]),
    .lane2_link_status(st2), .lane3_link_status(st3));

  // Free-running 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Sixteen-bit shift register, taps 16, 14, 13, 11
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Count one below, at or just above the threshold half the time, to hit the boundary
  function automatic logic [7:0] cnt(input logic [7:0] t);
    rnd = lfsr(rnd);
    return rnd[2] ? t + 8'(rnd[1:0]) - 8'h01 : rnd[15:8];
  endfunction

  // Reference flags; alignment-dependent bits read 0 while alignment is skipped
  function automatic logic [7:0] flags(input logic [28:0] v, input logic [7:0] t,
                                       input logic sk);
    return {v[28:21] >= t, v[20:13] >= t, v[12:5] >= t, sk ? 4'h0 : v[4:1], v[0]};
  endfunction

  // One comparison; reports a mismatch at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Everything the design drives must be cleared while reset is held
  task automatic zero_check();
    chk(st2, STATUS_RESET);
    chk(st3, STATUS_RESET);
    chk(cfg_rd_data, 8'h00);
    chk({6'h00, cfg_rd_valid, cfg_wr_refused}, 8'h00);
  endtask

  // Release at a falling edge; the next rising edge loads the live lane state
  task automatic release_reset();
    cfg_rd_en = 1'b0;
    cfg_wr_en = 1'b0;
    reset = 1'b0;
    exp2 = flags(lane_plan[28:0], thr, skip);
    exp3 = flags(lane_plan[57:29], thr, skip);
    rdq.delete();
    wr_pend = 1'b0;
    rd_last = READ_UNMAPPED;
  endtask

  // Each cycle: check last cycle's answers, then drive fresh random traffic
  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      chk(st2, exp2);
      chk(st3, exp3);
      chk({7'h00, cfg_rd_valid}, {7'h00, rdq.size() != 0});
      // Read data is checked every cycle, so it must also hold between reads
      if (rdq.size() != 0) rd_last = rdq.pop_front();
      chk(cfg_rd_data, rd_last);
      chk({7'h00, cfg_wr_refused}, {7'h00, wr_pend});
      rnd = lfsr(rnd);
      thr = thr_nxt;
      skip = rnd[7];
      cfg_rd_en = rnd[6];
      cfg_wr_en = rnd[5];
      cfg_wr_data = rnd[15:8] ^ 8'hA5;
      // Both flag registers, the offset just above lane 3 and scattered unmapped offsets
      case (rnd[1:0])
        2'd0: cfg_addr = LANE2_STATUS_ADDR;
        2'd1: cfg_addr = LANE3_STATUS_ADDR;
        2'd2: cfg_addr = LANE3_STATUS_ADDR + 12'h001;
        default: cfg_addr = {rnd[3:0], rnd[15:8]};
      endcase
      // A read returns the flags as they stand at the strobe edge
      if (cfg_rd_en) begin
        rdq.push_back(cfg_addr == LANE2_STATUS_ADDR ? exp2 :
                      cfg_addr == LANE3_STATUS_ADDR ? exp3 : READ_UNMAPPED);
      end
      wr_pend = cfg_wr_en && (cfg_addr == LANE2_STATUS_ADDR || cfg_addr == LANE3_STATUS_ADDR);
      // The model loads the old plan now, so the flags follow it and the new threshold
      exp2 = flags(lane_plan[28:0], thr, skip);
      exp3 = flags(lane_plan[57:29], thr, skip);
      rnd = lfsr(rnd);
      thr_nxt = rnd[3] ? rnd[15:8] : {8{rnd[4]}};
      lane_plan <= {cnt(thr_nxt), cnt(thr_nxt), cnt(thr_nxt), rnd[9:5],
                    cnt(thr_nxt), cnt(thr_nxt), cnt(thr_nxt), rnd[14:10]};
    end
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reset, random traffic, a reset in mid-run, more traffic
  initial begin
    err_total = 0;
    checks = 0;
    rnd = 16'h0029;
    reset = 1'b1;
    {cfg_rd_en, cfg_wr_en, skip, wr_pend} = 4'h0;
    cfg_addr = '0;
    cfg_wr_data = '0;
    {thr, thr_nxt} = 16'h0000;
    lane_plan = '0;
    repeat (3) @(negedge core_clk);
    zero_check();
    release_reset();
    run(600);
    reset = 1'b1;
    @(negedge core_clk);
    zero_check();
    release_reset();
    run(600);
    tally_and_finish();
  end
endmodule
`default_nettype wire
